// ===== sim/pwm_fault_limit_override_tb_top.sv
// Register and pin tests of the channel override block
`include "pwmfl_defs.vh"
`default_nettype none
module pwm_fault_limit_override_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, gen_high = 0, gen_low = 0, tb_wrap = 0, lim = 0, flt = 0;
    logic [1:0] htrans = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
    logic [15:0] tb_count = 0, fault_pins, low_tb_count;
    logic hreadyout, hresp, hs, ls, adc, lwrap;
    int miscompares = 0, cmp_count = 0, cyc = 0, trig_seen, n;
    logic rdy_s = 1;
    logic [31:0] rdata_s = 0;
    always #4 hclk = ~hclk;
    // Settled copies, so a rising edge sees the value that stood before it
    always @(negedge hclk)
    begin
        rdy_s <= hreadyout;
        rdata_s <= hrdata;
    end
    pwmfl_top uut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .gen_high, .gen_low, .tb_count, .tb_wrap,
        .fault_pins, .high_side_output(hs), .low_side_output(ls), .adc_trigger(adc), .low_tb_count,
        .low_tb_wrap(lwrap));
    pwmfl_stage_model u_stage (.hclk, .adc_trigger(adc), .limit_req(lim), .fault_req(flt), .fault_pins,
        .trig_seen);
    task test_done;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wait_rdy;
        n = 0;
        @(posedge hclk);
        while (rdy_s !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge hclk);
        end
        if (n >= 20)
            miscompares++;
    endtask
    task wr(input logic [31:0] a, input logic [15:0] v);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1;
        wait_rdy;
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= {16'h0, v};
        wait_rdy;
    endtask
    task rc(input logic [31:0] a, input logic [31:0] e);
        hsel <= 1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 0;
        wait_rdy;
        hsel <= 0;
        htrans <= 2'h0;
        wait_rdy;
        chk(rdata_s, e);
    endtask
    // Settings change only with the channel stopped
    task cfg(input logic [15:0] io, input logic [15:0] fl);
        wr(`PWMFL_OFS_TBCTL, 16'h0000);
        wr(`PWMFL_OFS_IOCTL, io);
        wr(`PWMFL_OFS_FLCTL, fl);
        wr(`PWMFL_OFS_TBCTL, 16'h8000);
    endtask
    // Model launch, sync and register latency, one spare
    task pins(input logic [1:0] e);
        repeat (5) @(posedge hclk);
        chk(32'({hs, ls}), 32'(e));
    endtask
    task waitw;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end
        while (lwrap !== 1'b1 && n < 100);
    endtask
    always @(posedge hclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            miscompares++;
            test_done;
        end
    end
    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1;
        @(posedge hclk);
        rc(`PWMFL_OFS_IOCTL, 32'h0);
        rc(`PWMFL_OFS_TRIG, 32'h0);
        rc(`PWMFL_OFS_FLCTL, 32'h00f8);
        wr(`PWMFL_OFS_TRIG, 16'hffff);
        rc(`PWMFL_OFS_TRIG, 32'hfff8);
        wr(32'h20, 16'h1234);
        rc(32'h20, 32'h0);
        rc(`PWMFL_OFS_IOCTL, 32'h0);
        $display("register test done");
        gen_high <= 1;
        cfg(16'h0000, 16'h00fb);
        pins(2'b10);
        cfg(16'h0002, 16'h00fb);
        pins(2'b01);
        cfg(16'h8000, 16'h00fb);
        pins(2'b00);
        cfg(16'h0201, 16'h00fb);
        pins(2'b10);
        tb_wrap <= 1;
        @(posedge hclk);
        tb_wrap <= 0;
        pins(2'b00);
        $display("swap and override test done");
        gen_high <= 0;
        gen_low <= 1;
        lim <= 1;
        cfg(16'h0008, 16'h01fb);
        pins(2'b10);
        cfg(16'h0008, 16'h00fb);
        pins(2'b01);
        cfg(16'h0008, 16'h03fb);
        pins(2'b01);
        lim <= 0;
        pins(2'b10);
        lim <= 1;
        gen_low <= 0;
        cfg(16'h0024, 16'h81fb);
        pins(2'b10);
        lim <= 0;
        flt <= 1;
        cfg(16'h0010, 16'h8108);
        pins(2'b01);
        gen_low <= 1;
        cfg(16'h0020, 16'h0008);
        pins(2'b10);
        flt <= 0;
        $display("limit and fault test done");
        wr(`PWMFL_OFS_SPHASE, 16'h0033);
        tb_count <= 16'h0005;
        repeat (3) @(posedge hclk);
        chk(32'(low_tb_count), 32'h5);
        cfg(16'h0c00, 16'h00fb);
        wr(`PWMFL_OFS_PHASE, 16'h0010);
        tb_count <= 16'h0005;
        repeat (3) @(posedge hclk);
        chk(32'(low_tb_count), 32'h15);
        wr(`PWMFL_OFS_TBCTL, 16'h0000);
        wr(`PWMFL_OFS_CHCTL, 16'h0200);
        wr(`PWMFL_OFS_TBCTL, 16'h8000);
        waitw;
        waitw;
        chk(32'(n), 32'd17);
        $display("time base test done");
        wr(`PWMFL_OFS_TBCTL, 16'h0000);
        wr(`PWMFL_OFS_CHCTL, 16'h0008);
        wr(`PWMFL_OFS_TRIG, 16'h002b);
        wr(`PWMFL_OFS_TBCTL, 16'h8000);
        for (int i = 16'h20; i < 16'h30; i++)
        begin
            tb_count <= 16'(i);
            @(posedge hclk);
        end
        repeat (3) @(posedge hclk);
        chk(32'(trig_seen), 32'd1);
        $display("trigger test done");
        test_done;
    end
endmodule // pwm_fault_limit_override_tb_top
`default_nettype wire

// ===== sim/pwmfl_props.sv
// Port checker for bus answers, read data and trigger pulses
`include "pwmfl_defs.vh"
`default_nettype none
module pwmfl_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [15:0] tb_count,
    input wire logic adc_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_r, wr_r, trig_r, unm_r;
    logic [15:0] cmp_r;
    wire take = hsel && htrans[1] && hready;
    wire rd_done = rd_r && hreadyout;
    // Shadow of the compare value, taken from the bus itself
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_r <= 1'b0;
            wr_r <= 1'b0;
            trig_r <= 1'b0;
            unm_r <= 1'b0;
            cmp_r <= 16'h0000;
        end
        else if (hready)
        begin
            if (wr_r && trig_r)
                cmp_r <= hwdata[15:0] & `PWMFL_TRIG_MASK;
            rd_r <= take && !hwrite;
            wr_r <= take && hwrite;
            trig_r <= haddr[31:2] == 30'h1;
            unm_r <= haddr[31:5] != 27'h0;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    chk_write_nowait: assert property (take && hwrite |=> hreadyout)
        else $error("write stalled");
    chk_upper_zero: assert property (rd_done |-> hrdata[31:16] == 16'h0000)
        else $error("upper read bits set");
    chk_trig_low: assert property (rd_done && trig_r |-> hrdata[2:0] == 3'h0)
        else $error("trigger low bits not zero");
    chk_unmapped_zero: assert property (rd_done && unm_r |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_read_hold: assert property (!rd_done |-> $stable(hrdata))
        else $error("read data moved");
    chk_trig_match: assert property (adc_trigger |-> $past(tb_count) == $past(cmp_r))
        else $error("trigger without compare match");
    cov_read: cover property (rd_done && trig_r);
    cov_write: cover property (take && hwrite);
    cov_trig: cover property (adc_trigger);
endmodule // pwmfl_props
bind pwmfl_top pwmfl_props u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .tb_count, .adc_trigger);
`default_nettype wire

// ===== sim/pwmfl_stage_model.sv
// Power stage and converter model: raises limit and fault pins, counts triggers
`default_nettype none
module pwmfl_stage_model (
    input wire logic hclk,
    input wire logic adc_trigger,
    input wire logic limit_req,
    input wire logic fault_req,
    output logic [15:0] fault_pins,
    output int trig_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    initial trig_seen = 0;
    // Pin 0 carries the limit sense, pin 1 the fault sense
    always @(posedge hclk)
    begin
        fault_pins <= {14'h0, fault_req, limit_req};
        if (adc_trigger === 1'b1)
            trig_seen <= trig_seen + 1;
    end
endmodule // pwmfl_stage_model
`default_nettype wire

// ===== verilog/pwmfl_defs.vh
// Register map, field positions and reset values of the channel override block
`ifndef PWMFL_DEFS_VH
`define PWMFL_DEFS_VH
`define PWMFL_ADDR_W 5
`define PWMFL_OFS_IOCTL 5'h00
`define PWMFL_OFS_TRIG 5'h04
`define PWMFL_OFS_FLCTL 5'h08
`define PWMFL_OFS_CHCTL 5'h0c
`define PWMFL_OFS_TBCTL 5'h10
`define PWMFL_OFS_PHASE 5'h14
`define PWMFL_OFS_SPHASE 5'h18
`define PWMFL_OFS_STATUS 5'h1c
`define PWMFL_IO_HIGH_SIDE_POLARITY 15
`define PWMFL_IO_POLL 14
`define PWMFL_IO_MODE_HI 11
`define PWMFL_IO_MODE_LO 10
`define PWMFL_IO_OVRENH 9
`define PWMFL_IO_OVRENL 8
`define PWMFL_IO_OVR_HI 7
`define PWMFL_IO_OVR_LO 6
`define PWMFL_IO_FLT_HI 5
`define PWMFL_IO_FLT_LO 4
`define PWMFL_IO_CL_HI 3
`define PWMFL_IO_CL_LO 2
`define PWMFL_IO_SWAP 1
`define PWMFL_IO_OVERRIDE_SYNC 0
`define PWMFL_MODE_INDEP 2'h3
`define PWMFL_FL_IFLT 15
`define PWMFL_FL_LIMIT_SOURCE_SELECT_HI 14
`define PWMFL_FL_LIMIT_SOURCE_SELECT_LO 10
`define PWMFL_FL_LIMIT_POLARITY 9
`define PWMFL_FL_LIMIT_MODE_ENABLE 8
`define PWMFL_FL_FSRC_HI 7
`define PWMFL_FL_FSRC_LO 3
`define PWMFL_FL_FPOL 2
`define PWMFL_FL_FMOD_HI 1
`define PWMFL_FL_FMOD_LO 0
`define PWMFL_FMOD_OFF 2'h3
`define PWMFL_CH_ITB 9
`define PWMFL_CH_LOCAL 3
`define PWMFL_TB_EN 15
`define PWMFL_IOCTL_RST 16'h0000
`define PWMFL_TRIG_RST 16'h0000
`define PWMFL_FLCTL_RST 16'h00f8
`define PWMFL_REG_RST 16'h0000
`define PWMFL_TRIG_MASK 16'hfff8
`endif

// ===== verilog/pwmfl_ltb.v
// Low-side time base: phase shift or independent local period
`default_nettype none
module pwmfl_ltb (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire [15:0] tb_count,
    input wire indep_mode,
    input wire indep_period,
    input wire [15:0] phase,
    output reg [15:0] low_count_r,
    output reg low_wrap_r
);
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            low_count_r <= 16'h0000;
            low_wrap_r <= 1'b0;
        end
        else if (ce)
        begin
            low_wrap_r <= 1'b0;
            if (indep_mode && indep_period)
            begin
                // Own period for the low side [RULE_03]
                if (low_count_r >= phase)
                begin
                    low_count_r <= 16'h0000;
                    low_wrap_r <= 1'b1;
                end
                else
                    low_count_r <= low_count_r + 16'h0001;
            end
            else if (indep_mode)
                low_count_r <= tb_count + phase; // [RULE_01]
            else
                low_count_r <= tb_count; // Secondary phase unused here [RULE_02]
        end
    end
endmodule // pwmfl_ltb
`default_nettype wire

// ===== verilog/pwmfl_sync2.v
// Two-flop synchroniser for asynchronous pin inputs
`default_nettype none
module pwmfl_sync2 #(
    parameter W = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
    reg [W-1:0] meta_r;

    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end
        else if (ce)
        begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pwmfl_sync2
`default_nettype wire

// ===== verilog/pwmfl_top.v
// Channel output override, fault and current-limit control with AHB-Lite registers
`include "pwmfl_defs.vh"
`default_nettype none
// Notes on behaviour
// RULE_01: Independent mode, no own period: phase shifts low
// RULE_02: Other output modes ignore the secondary phase
// RULE_03: Independent mode with own period: phase is low period
// RULE_04: Software keeps local period within permitted range
// RULE_05: Normal mode limit drives limit state bits
// RULE_06: Limit states apply only with limit mode on
// RULE_07: Independent fault mode ignores limit state bits
// RULE_08: Swap exchanges high and low generator signals
// RULE_09: Override change on time base or next clock
// RULE_10: Software leaves I/O settings alone once enabled
// RULE_11: Override states are active levels, polarity applies
// RULE_12: Thirteen-bit trigger compare raises ADC trigger
// RULE_13: Independent mode: limit to high, fault to low
// RULE_14: Normal mode: each source drives both outputs
// RULE_15: Limit polarity bit selects active-low source
// RULE_16: Software changes polarities only while disabled
module pwmfl_top (
    input wire hclk,
    input wire hresetn,
    input wire ce,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire gen_high,
    input wire gen_low,
    input wire [15:0] tb_count,
    input wire tb_wrap,
    input wire [15:0] fault_pins,
    output reg high_side_output,
    output reg low_side_output,
    output reg adc_trigger,
    output wire [15:0] low_tb_count,
    output wire low_tb_wrap
);
    reg [15:0] io_override_control_r;
    reg [15:0] trigger_compare_value_r;
    reg [15:0] fault_limit_control_r;
    reg [15:0] channel_control_reg_r;
    reg [15:0] timebase_control_reg_r;
    reg [15:0] primary_phase_reg_r;
    reg [15:0] secondary_phase_reg_r;
    reg [3:0] ovr_act_r;
    reg wr_pend_r;
    reg rd_pend_r;
    reg [`PWMFL_ADDR_W-1:0] addr_r;
    reg limit_act_r;
    reg fault_act_r;
    reg [15:0] rd_mux;
    wire [15:0] pins_s;
    wire addr_take;
    wire [1:0] mode;
    wire indep_fault;
    wire [4:0] cl_src;
    wire [4:0] flt_src;
    wire limit_raw;
    wire fault_raw;
    wire limit_on;
    wire fault_on;
    wire global_pwm_enable;
    wire [3:0] ovr_req;
    wire sw_h;
    wire sw_l;
    reg act_h;
    reg act_l;

    // Reserved source codes above the pin count read as a low pin, active if the polarity bit is set
    function pick_src;
        input [15:0] pins;
        input [4:0] sel;
        begin
            if (sel[4])
                pick_src = 1'b0;
            else
                pick_src = pins[sel[3:0]];
        end
    endfunction

    function [15:0] wdata16;
        input [31:0] w;
        begin
            wdata16 = w[15:0];
        end
    endfunction

    pwmfl_sync2 #(
        .W(16)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(fault_pins),
        .q(pins_s)
    );

    pwmfl_ltb u_ltb (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .tb_count(tb_count),
        .indep_mode(mode == `PWMFL_MODE_INDEP),
        .indep_period(channel_control_reg_r[`PWMFL_CH_ITB]),
        .phase(primary_phase_reg_r),
        .low_count_r(low_tb_count),
        .low_wrap_r(low_tb_wrap)
    );

    assign addr_take = hsel && htrans[1] && hready;
    assign mode = io_override_control_r[`PWMFL_IO_MODE_HI:`PWMFL_IO_MODE_LO];
    assign indep_fault = fault_limit_control_r[`PWMFL_FL_IFLT];
    assign cl_src = fault_limit_control_r[`PWMFL_FL_LIMIT_SOURCE_SELECT_HI:`PWMFL_FL_LIMIT_SOURCE_SELECT_LO];
    assign flt_src = fault_limit_control_r[`PWMFL_FL_FSRC_HI:`PWMFL_FL_FSRC_LO];
    assign global_pwm_enable = timebase_control_reg_r[`PWMFL_TB_EN];

    // Source polarity, limit gated by its mode bit
    assign limit_raw = pick_src(pins_s, cl_src) ^ fault_limit_control_r[`PWMFL_FL_LIMIT_POLARITY]; // [RULE_15]
    assign fault_raw = pick_src(pins_s, flt_src) ^ fault_limit_control_r[`PWMFL_FL_FPOL];
    assign limit_on = limit_raw && fault_limit_control_r[`PWMFL_FL_LIMIT_MODE_ENABLE]; // [RULE_06]
    assign fault_on = fault_raw &&
        (fault_limit_control_r[`PWMFL_FL_FMOD_HI:`PWMFL_FL_FMOD_LO] != `PWMFL_FMOD_OFF);

    // Override enables and states {enh, enl, sth, stl}
    assign ovr_req = {io_override_control_r[`PWMFL_IO_OVRENH], io_override_control_r[`PWMFL_IO_OVRENL],
        io_override_control_r[`PWMFL_IO_OVR_HI], io_override_control_r[`PWMFL_IO_OVR_LO]};

    assign sw_h = io_override_control_r[`PWMFL_IO_SWAP] ? gen_low : gen_high; // [RULE_08]
    assign sw_l = io_override_control_r[`PWMFL_IO_SWAP] ? gen_high : gen_low; // [RULE_08]

    // Active levels, highest priority first: fault, limit, override, generator
    always @*
    begin
        act_h = global_pwm_enable & sw_h;
        act_l = global_pwm_enable & sw_l;
        if (ovr_act_r[3])
            act_h = ovr_act_r[1];
        if (ovr_act_r[2])
            act_l = ovr_act_r[0];
        if (indep_fault)
        begin
            // Limit state bits play no part here [RULE_07]
            if (limit_on)
                act_h = io_override_control_r[`PWMFL_IO_FLT_HI]; // [RULE_13]
            if (fault_on)
                act_l = io_override_control_r[`PWMFL_IO_FLT_LO]; // [RULE_13]
        end
        else if (fault_on)
        begin
            act_h = io_override_control_r[`PWMFL_IO_FLT_HI]; // [RULE_14]
            act_l = io_override_control_r[`PWMFL_IO_FLT_LO]; // [RULE_14]
        end
        else if (limit_on)
        begin
            act_h = io_override_control_r[`PWMFL_IO_CL_HI]; // [RULE_05] [RULE_14]
            act_l = io_override_control_r[`PWMFL_IO_CL_LO]; // [RULE_05] [RULE_14]
        end
    end

    // Pins, override staging and trigger
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            high_side_output <= 1'b0;
            low_side_output <= 1'b0;
            ovr_act_r <= 4'h0;
            adc_trigger <= 1'b0;
            limit_act_r <= 1'b0;
            fault_act_r <= 1'b0;
        end
        else if (ce)
        begin
            // Polarity set means the pin is low when active [RULE_11]
            high_side_output <= act_h ^ io_override_control_r[`PWMFL_IO_HIGH_SIDE_POLARITY];
            low_side_output <= act_l ^ io_override_control_r[`PWMFL_IO_POLL];
            // Time base alignment avoids runt pulses on override changes
            if (!io_override_control_r[`PWMFL_IO_OVERRIDE_SYNC] || tb_wrap)
                ovr_act_r <= ovr_req; // [RULE_09]
            // Compare on all 16 count bits against a value whose low three bits are always zero [RULE_12]
            adc_trigger <= channel_control_reg_r[`PWMFL_CH_LOCAL] && global_pwm_enable &&
                (tb_count == trigger_compare_value_r);
            limit_act_r <= limit_on;
            fault_act_r <= fault_on;
        end
    end

    // Register read view
    always @*
    begin
        rd_mux = 16'h0000;
        case (addr_r)
            `PWMFL_OFS_IOCTL:
                rd_mux = io_override_control_r;
            `PWMFL_OFS_TRIG:
                rd_mux = trigger_compare_value_r;
            `PWMFL_OFS_FLCTL:
                rd_mux = fault_limit_control_r;
            `PWMFL_OFS_CHCTL:
                rd_mux = channel_control_reg_r;
            `PWMFL_OFS_TBCTL:
                rd_mux = timebase_control_reg_r;
            `PWMFL_OFS_PHASE:
                rd_mux = primary_phase_reg_r;
            `PWMFL_OFS_SPHASE:
                rd_mux = secondary_phase_reg_r;
            `PWMFL_OFS_STATUS:
                rd_mux = {12'h000, fault_act_r, limit_act_r, high_side_output, low_side_output};
            default:
                rd_mux = 16'h0000;
        endcase
    end

    // AHB-Lite slave: writes zero wait, reads one wait so a prior write is seen
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= {`PWMFL_ADDR_W{1'b0}};
            io_override_control_r <= `PWMFL_IOCTL_RST;
            trigger_compare_value_r <= `PWMFL_TRIG_RST;
            fault_limit_control_r <= `PWMFL_FLCTL_RST;
            channel_control_reg_r <= `PWMFL_REG_RST;
            timebase_control_reg_r <= `PWMFL_REG_RST;
            primary_phase_reg_r <= `PWMFL_REG_RST;
            secondary_phase_reg_r <= `PWMFL_REG_RST;
        end
        else if (ce)
        begin
            hresp <= 1'b0;
            if (wr_pend_r)
            begin
                wr_pend_r <= 1'b0;
                case (addr_r)
                    `PWMFL_OFS_IOCTL:
                        io_override_control_r <= wdata16(hwdata);
                    `PWMFL_OFS_TRIG:
                        trigger_compare_value_r <= wdata16(hwdata) & `PWMFL_TRIG_MASK; // [RULE_12]
                    `PWMFL_OFS_FLCTL:
                        fault_limit_control_r <= wdata16(hwdata);
                    `PWMFL_OFS_CHCTL:
                        channel_control_reg_r <= wdata16(hwdata);
                    `PWMFL_OFS_TBCTL:
                        timebase_control_reg_r <= wdata16(hwdata);
                    `PWMFL_OFS_PHASE:
                        primary_phase_reg_r <= wdata16(hwdata);
                    `PWMFL_OFS_SPHASE:
                        secondary_phase_reg_r <= wdata16(hwdata);
                    default:
                        wr_pend_r <= 1'b0;
                endcase
            end
            if (rd_pend_r)
            begin
                rd_pend_r <= 1'b0;
                hrdata <= {16'h0000, rd_mux};
                hreadyout <= 1'b1;
            end
            else if (addr_take)
            begin
                addr_r <= haddr[`PWMFL_ADDR_W-1:0] & {{(`PWMFL_ADDR_W-2){1'b1}}, 2'b00};
                if (haddr[31:`PWMFL_ADDR_W] != {(32-`PWMFL_ADDR_W){1'b0}})
                    addr_r <= {`PWMFL_ADDR_W{1'b1}};
                wr_pend_r <= hwrite;
                if (!hwrite)
                begin
                    rd_pend_r <= 1'b1;
                    hreadyout <= 1'b0;
                end
            end
        end
    end
endmodule // pwmfl_top
`default_nettype wire
